//--- src/pwm_script_instruction_executor.sv
// Three PWM script engines: script storage, instruction decode and execution, PWM outputs.
// Assumes slow_clk is the 32.768 kHz clock sampled as a level synchronous to clock,
// and host start, stop and script writes arrive as one-cycle pulses on clock.
`timescale 1ns/1ns
`default_nettype none

`include "pwm_script_regs.svh"

module pwm_script_instruction_executor
  import pwm_script_pkg::*;
(
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          ce,
  input  wire logic          slow_clk,
  input  wire script_write_t script_wr,
  input  wire logic [2:0]    start_req,
  input  wire logic [5:0]    start_addr,
  input  wire logic [2:0]    stop_req,
  output logic [2:0]         pwm_out,
  output logic [2:0]         pwm_oe,
  output logic [2:0]         end_irq,
  output logic [2:0]         engine_busy
);

  // ---------------------------------------------------------------
  // Script command file
  // ---------------------------------------------------------------
  logic [15:0] script_mem [0:`NUM_CHAN-1][0:`SCRIPT_DEPTH-1];

  always_ff @(posedge clock) begin
    if (ce && script_wr.valid && script_wr.chan < 2'h3) begin
      script_mem[script_wr.chan][script_wr.addr] <= script_wr.data;
    end
  end

  // ---------------------------------------------------------------
  // Engine state
  // ---------------------------------------------------------------
  state_t          st;
  state_t          next_st;
  logic            tick;
  logic [15:0]     w;
  logic [5:0]      cur;
  logic [8:0]      div_last;
  logic [2:0][2:0] sync_set;
  logic [2:0][2:0] sync_clr;

  always_comb begin
    next_st           = st;
    tick              = slow_clk & ~st.slow_prev;
    next_st.slow_prev = slow_clk;
    w                 = 16'h0000;
    cur               = 6'h00;
    div_last          = `DIV_LO_LAST;
    sync_set          = '0;
    sync_clr          = '0;
    for (int c = 0; c < `NUM_CHAN; c++) begin
      next_st.ch[c].irq = 1'b0;
      // Requests wait in a pending flag until the next slow tick
      if (start_req[c]) begin
        next_st.ch[c].start_pend = 1'b1;
        next_st.ch[c].start_at   = start_addr;
      end
      if (stop_req[c]) begin
        next_st.ch[c].stop_pend = 1'b1;
      end
      if (tick) begin
        if (st.ch[c].period_on) begin
          next_st.ch[c].period = 8'(st.ch[c].period + 8'h01);
        end
        // A stop cannot cut a ramp short; it is honoured when the ramp ends
        if (st.ch[c].stop_pend && st.ch[c].phase != PH_RAMP) begin
          next_st.ch[c].stop_pend = stop_req[c];
          next_st.ch[c].irq       = st.ch[c].phase != PH_IDLE && st.ch[c].phase != PH_SYNC;
          next_st.ch[c].phase     = PH_IDLE;
        end else if (st.ch[c].start_pend) begin
          next_st.ch[c].start_pend = start_req[c];
          next_st.ch[c].phase      = PH_FETCH;
          next_st.ch[c].pc         = st.ch[c].start_at;
          next_st.ch[c].loop_on    = 1'b0;
          next_st.ch[c].oe         = 1'b1;
        end else begin
          case (st.ch[c].phase)
            PH_FETCH: begin
              w                    = script_mem[c][st.ch[c].pc];
              next_st.ch[c].instr  = w;
              next_st.ch[c].pc     = 6'(st.ch[c].pc + 6'h01);
              if (!w[`OP_BIT]) begin
                if (w == `RESTART_WORD) begin
                  next_st.ch[c].pc = 6'h00;
                end else if (w[`STEP_LEN_HI:`STEP_LEN_LO] == 6'h00) begin
                  next_st.ch[c].ramp = w[`LEVEL_HI:`LEVEL_LO];
                end else begin
                  // The period counter starts with the first ramp
                  next_st.ch[c].steps     = w[`STEPS_HI:`STEPS_LO];
                  next_st.ch[c].presc     = 9'h000;
                  next_st.ch[c].stime     = 6'h00;
                  next_st.ch[c].period_on = 1'b1;
                  next_st.ch[c].phase     = PH_RAMP;
                end
              end else if (w[15:13] == `OPC_BRANCH) begin
                cur = st.ch[c].loop_on ? st.ch[c].loop_cnt
                                       : 6'(w[`REPEAT_HI:`REPEAT_LO] - 6'h01);
                if (w[`TARGET_HI:`TARGET_LO] > `MAX_TARGET) begin
                  next_st.ch[c].loop_on = 1'b0;
                end else if (w[`REPEAT_HI:`REPEAT_LO] == 6'h00) begin
                  next_st.ch[c].pc = w[`TARGET_HI:`TARGET_LO];
                end else if (cur == 6'h00) begin
                  next_st.ch[c].loop_on = 1'b0;
                end else begin
                  // One repeat count only: a nested branch would share it
                  next_st.ch[c].loop_on  = 1'b1;
                  next_st.ch[c].loop_cnt = 6'(cur - 6'h01);
                  next_st.ch[c].pc       = w[`TARGET_HI:`TARGET_LO];
                end
              end else if (w[15:12] == `OPC_END) begin
                next_st.ch[c].phase = PH_IDLE;
                next_st.ch[c].irq   = 1'b1;
                if (w[`TRISTATE_BIT]) begin
                  next_st.ch[c].oe        = 1'b0;
                  next_st.ch[c].period_on = 1'b0;
                end
                // Tristate bit clear: period counter and duty stay as they are
              end else if (w[15:13] == `OPC_SYNC) begin
                for (int r = 0; r < `NUM_CHAN; r++) begin
                  sync_set[r][c] = sync_set[r][c] | w[`EMIT_LO + r];
                end
                // Decode tick is the first of the sixteen
                next_st.ch[c].sync_cnt = `SYNC_FIRST;
                next_st.ch[c].phase    = PH_SYNC;
              end
              // Unused encodings fall through as no-operations
            end
            PH_RAMP: begin
              div_last = st.ch[c].instr[`DIV_SEL_BIT] ? `DIV_HI_LAST : `DIV_LO_LAST;
              next_st.ch[c].presc = 9'(st.ch[c].presc + 9'h001);
              if (st.ch[c].presc == div_last) begin
                next_st.ch[c].presc = 9'h000;
                next_st.ch[c].stime = 6'(st.ch[c].stime + 6'h01);
                if (st.ch[c].stime == 6'(st.ch[c].instr[`STEP_LEN_HI:`STEP_LEN_LO] - 6'h01)) begin
                  next_st.ch[c].stime = 6'h00;
                  if (st.ch[c].instr[`SIGN_BIT]) begin
                    if (st.ch[c].ramp != `RAMP_EMPTY) begin
                      next_st.ch[c].ramp = 8'(st.ch[c].ramp - 8'h01);
                    end
                  end else if (st.ch[c].ramp != `RAMP_FULL) begin
                    next_st.ch[c].ramp = 8'(st.ch[c].ramp + 8'h01);
                  end
                  next_st.ch[c].steps = 7'(st.ch[c].steps - 7'h01);
                  if (st.ch[c].steps == 7'h01) begin
                    next_st.ch[c].phase = PH_FETCH;
                  end
                end
              end
            end
            PH_SYNC: begin
              if (st.ch[c].sync_cnt != `SYNC_LAST) begin
                next_st.ch[c].sync_cnt = 4'(st.ch[c].sync_cnt + 4'h1);
              end else if ((st.ch[c].sync_seen & st.ch[c].instr[`AWAIT_HI:`AWAIT_LO])
                           == st.ch[c].instr[`AWAIT_HI:`AWAIT_LO]) begin
                sync_clr[c]         = st.ch[c].instr[`AWAIT_HI:`AWAIT_LO];
                next_st.ch[c].phase = PH_FETCH;
              end
            end
            default: begin
              next_st.ch[c].phase = PH_IDLE;
            end
          endcase
        end
      end
    end
    // ---------------------------------------------------------------
    // Sync latches and PWM compare
    // ---------------------------------------------------------------
    for (int r = 0; r < `NUM_CHAN; r++) begin
      // A sync arriving as it is consumed survives: set beats clear
      next_st.ch[r].sync_seen = (st.ch[r].sync_seen & ~sync_clr[r]) | sync_set[r];
      next_st.ch[r].pwm = next_st.ch[r].period_on
                          && next_st.ch[r].period <= next_st.ch[r].ramp;
      next_st.ch[r].busy = next_st.ch[r].phase != PH_IDLE;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < `NUM_CHAN; c++) begin
      pwm_out[c]     = st.ch[c].pwm;
      pwm_oe[c]      = st.ch[c].oe;
      end_irq[c]     = st.ch[c].irq;
      engine_busy[c] = st.ch[c].busy;
    end
  end

endmodule : pwm_script_instruction_executor

`default_nettype wire

//--- inc/pwm_script_regs.svh
// Constants of the PWM script executor: instruction fields, opcodes and timing counts.
// Assumes inclusion by the package and the design file only.
`ifndef PWM_SCRIPT_REGS_SVH
`define PWM_SCRIPT_REGS_SVH

`define NUM_CHAN          3
`define SCRIPT_DEPTH      64
`define MAX_TARGET        6'h3B
`define RESTART_WORD      16'h0000

// Instruction field positions
`define OP_BIT            15
`define DIV_SEL_BIT       14
`define STEP_LEN_HI       13
`define STEP_LEN_LO       8
`define SIGN_BIT          7
`define STEPS_HI          6
`define STEPS_LO          0
`define LEVEL_HI          7
`define LEVEL_LO          0
`define REPEAT_HI         12
`define REPEAT_LO         7
`define TARGET_HI         5
`define TARGET_LO         0
`define TRISTATE_BIT      11
`define AWAIT_HI          9
`define AWAIT_LO          7
`define EMIT_HI           3
`define EMIT_LO           1

// Opcodes
`define OPC_BRANCH        3'h5
`define OPC_SYNC          3'h7
`define OPC_END           4'hC

// Prescaler: last count of the divide-by-16 and divide-by-512 settings
`define DIV_LO_LAST       9'h00F
`define DIV_HI_LAST       9'h1FF

// A sync instruction lasts at least 16 slow-clock cycles; the decode cycle is the first
`define SYNC_TICKS        5'h10
`define SYNC_LAST         4'hF
`define SYNC_FIRST        4'h1

`define RAMP_FULL         8'hFF
`define RAMP_EMPTY        8'h00

`endif

//--- inc/pwm_script_pkg.sv
// Types of the PWM script executor: engine phases, engine state and host write carrier.
// Assumes pwm_script_regs.svh is on the include path.
`include "pwm_script_regs.svh"

package pwm_script_pkg;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_FETCH,
    PH_RAMP,
    PH_SYNC
  } phase_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  chan;
    logic [5:0]  addr;
    logic [15:0] data;
  } script_write_t;

  typedef struct packed {
    phase_t      phase;
    logic [5:0]  pc;
    logic [15:0] instr;
    logic [7:0]  ramp;
    logic [6:0]  steps;
    logic [8:0]  presc;
    logic [5:0]  stime;
    logic [5:0]  loop_cnt;
    logic        loop_on;
    logic [3:0]  sync_cnt;
    logic [2:0]  sync_seen;
    logic        start_pend;
    logic [5:0]  start_at;
    logic        stop_pend;
    logic [7:0]  period;
    logic        period_on;
    logic        pwm;
    logic        oe;
    logic        irq;
    logic        busy;
  } chan_t;

  typedef struct packed {
    logic                slow_prev;
    chan_t [2:0]         ch;
  } state_t;

endpackage : pwm_script_pkg

//--- dv/pwm_script_asserts.sv
// Port checks for the PWM script executor, bound to its top module.
// Assumes ce stays high, so every rise of slow_clk is one tick.
`timescale 1ns/1ns
`default_nettype none
module pwm_script_asserts
  import pwm_script_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          ce,
  input wire logic          slow_clk,
  input wire script_write_t script_wr,
  input wire logic [2:0]    start_req,
  input wire logic [5:0]    start_addr,
  input wire logic [2:0]    stop_req,
  input wire logic [2:0]    pwm_out,
  input wire logic [2:0]    pwm_oe,
  input wire logic [2:0]    end_irq,
  input wire logic [2:0]    engine_busy
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [1:0] hist;
  wire        tick = hist[0] & ~hist[1];
  always_ff @(posedge clock or posedge rst) begin
    if (rst) hist <= 2'h0;
    else hist <= {hist[0], slow_clk};
  end
  sequence tick_s;
    tick;
  endsequence
  for (genvar c = 0; c < 3; c++) begin : g_ch
    sequence pulse_s;
      end_irq[c] ##1 !end_irq[c];
    endsequence
    irq_pulse_a: assert property ($rose(end_irq[c]) |-> pulse_s)
      else $error("end pulse wider than one cycle");
    irq_tick_a: assert property (end_irq[c] |-> tick_s)
      else $error("end pulse off a tick");
    irq_busy_a: assert property (end_irq[c] |-> !engine_busy[c] && $past(engine_busy[c]))
      else $error("end pulse without busy fall");
    busy_rise_a: assert property ($rose(engine_busy[c]) |-> tick_s)
      else $error("busy rose off a tick");
    busy_fall_a: assert property ($fell(engine_busy[c]) |-> tick_s)
      else $error("busy fell off a tick");
    pwm_move_a: assert property ($changed(pwm_out[c]) |-> tick || $past(tick))
      else $error("pwm moved between ticks");
    float_low_a: assert property (!pwm_oe[c] |-> !pwm_out[c])
      else $error("pwm high while released");
    start_busy_a: assert property (start_req[c] && !stop_req[c] |-> ##[1:1000] engine_busy[c])
      else $error("start not taken");
  end
endmodule : pwm_script_asserts
bind pwm_script_instruction_executor pwm_script_asserts i_pwm_script_asserts (
  .clock(clock), .rst(rst), .ce(ce), .slow_clk(slow_clk), .script_wr(script_wr),
  .start_req(start_req), .start_addr(start_addr), .stop_req(stop_req), .pwm_out(pwm_out),
  .pwm_oe(pwm_oe), .end_irq(end_irq), .engine_busy(engine_busy));
`default_nettype wire

//--- dv/led_load.sv
// LED loads on the three PWM pins and a count of host interrupt pulses.
// Assumes pwm_oe high means the pin is driven.
`timescale 1ns/1ns
`default_nettype none
module led_load (
  input  wire logic       clock,
  input  wire logic [2:0] pwm_out,
  input  wire logic [2:0] pwm_oe,
  input  wire logic [2:0] end_irq,
  output logic [2:0]      lit,
  output int              irqs
);
  // A released pin carries no current, so its LED stays dark
  assign lit = pwm_oe & pwm_out;
  initial irqs = 0;
  always @(posedge clock) irqs <= irqs + $countones(end_irq);
endmodule : led_load
`default_nettype wire

//--- dv/pwm_script_instruction_executor_test.sv
// Self-checking bench: ramps, loads, restart, branches, ends and syncs.
// Assumes the package, the checker bind and the LED model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module pwm_script_instruction_executor_test
  import pwm_script_pkg::*;
;
  logic          clock = 1'b0;
  logic          rst = 1'b1;
  logic          slow_clk = 1'b0;
  script_write_t script_wr = '0;
  logic [2:0]    start_req = 3'h0;
  logic [5:0]    start_addr = 6'h00;
  logic [2:0]    stop_req = 3'h0;
  logic [2:0]    pwm_out, pwm_oe, end_irq, engine_busy, lit;
  logic [3:0]    div = 4'h0;
  logic [1:0]    hist = 2'h0;
  logic [15:0]   w;
  logic [7:0]    lv, v;
  int            seed = 36;
  int            n_fail = 0;
  int            compares = 0;
  int            cyc = 0;
  int            irqs, n, h, s, l, r;
  wire           tick = hist[0] & ~hist[1];
  pwm_script_instruction_executor i_pwm_script_instruction_executor (
    .clock(clock), .rst(rst), .ce(1'b1), .slow_clk(slow_clk), .script_wr(script_wr),
    .start_req(start_req), .start_addr(start_addr), .stop_req(stop_req), .pwm_out(pwm_out),
    .pwm_oe(pwm_oe), .end_irq(end_irq), .engine_busy(engine_busy));
  led_load i_led_load (.clock(clock), .pwm_out(pwm_out), .pwm_oe(pwm_oe), .end_irq(end_irq),
    .lit(lit), .irqs(irqs));
  initial forever #20 clock = ~clock;
  // Slow tick every 8 clocks rather than about 763, to keep the run short
  always @(posedge clock) begin
    div <= div + 4'h1;
    slow_clk <= div[2];
    hist <= {hist[0], slow_clk};
    cyc++;
    if (cyc == 80000) begin
      n_fail++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [1:0] c, input logic [5:0] a, input logic [15:0] d);
    @(posedge clock);
    script_wr <= '{1'b1, c, a, d};
    @(posedge clock);
    script_wr.valid <= 1'b0;
  endtask : wr
  task automatic pulse(input int c, input logic go, input logic [5:0] a);
    @(posedge clock);
    start_addr <= a;
    if (go) start_req <= 3'h1 << c;
    else stop_req <= 3'h1 << c;
    @(posedge clock);
    {start_req, stop_req} <= 6'h00;
  endtask : pulse
  task automatic wait_end(input int c, input int lim);
    n = 0;
    while (end_irq[c] !== 1'b1 && n < lim) begin
      @(negedge clock);
      n += int'(tick);
    end
  endtask : wait_end
  task automatic run(input int c, input logic [5:0] a, input int lim);
    pulse(c, 1'b1, a);
    while (engine_busy[c] !== 1'b1) @(negedge clock);
    wait_end(c, lim);
  endtask : run
  function automatic int ticks(input logic [15:0] x);
    return 1 + int'(x[6:0]) * int'(x[13:8]) * (x[14] ? 512 : 16);
  endfunction : ticks
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      s = 1 + $unsigned($random(seed)) % 5;
      l = (k > 3) ? 1 : 1 + $unsigned($random(seed)) % 3;
      if (k > 3) s = (k == 4) ? 126 : 1;
      lv = k[0] ? 8'hFF : 8'h00;
      w = {1'b0, k == 5, 6'(l), k[1], 7'(s)};
      wr(0, 0, {8'h40, lv});
      wr(0, 1, w);
      wr(0, 2, 16'hC000);
      run(0, 0, 5000);
      chk("ramp ticks", 16'(n), 16'(2 + ticks(w)));
      chk("kept oe", {15'h0, pwm_oe[0]}, 16'h1);
      v = k[1] ? ((lv > s) ? lv - 8'(s) : 8'h00) : ((lv + s > 255) ? 8'hFF : lv + 8'(s));
      h = 0;
      repeat (256) begin
        do @(negedge clock); while (!tick);
        h += int'(pwm_out[0]);
      end
      chk("duty", 16'(h), {8'h00, v} + 16'h1);
    end
    $display("ramp test done");
    wr(0, 1, 16'h0101);
    wr(0, 2, 16'hC800);
    run(0, 0, 100);
    chk("float ticks", 16'(n), 16'd19);
    chk("float oe", {13'h0, pwm_oe[0], pwm_out[0], lit[0]}, 16'h0);
    wr(0, 9, 16'h0000);
    wr(0, 0, 16'hC000);
    run(0, 9, 100);
    chk("restart ticks", 16'(n), 16'd2);
    r = 1 + $unsigned($random(seed)) % 4;
    wr(1, 0, 16'h4000);
    wr(1, 1, 16'hA000 | 16'(r << 7));
    wr(1, 2, 16'hC000);
    run(1, 0, 100);
    chk("loop ticks", 16'(n), 16'(1 + 2 * r));
    wr(1, 1, 16'hA1BC);
    run(1, 0, 100);
    chk("far target", 16'(n), 16'd3);
    wr(1, 1, 16'hA000);
    run(1, 0, 40);
    chk("endless", {15'h0, engine_busy[1]}, 16'h1);
    pulse(1, 1'b0, 6'h00);
    wait_end(1, 10);
    chk("stop end", {14'h0, end_irq[1], engine_busy[1]}, 16'h2);
    $display("branch test done");
    wr(2, 0, 16'hE002);
    wr(2, 1, 16'hC000);
    wr(0, 0, 16'hE200);
    wr(0, 1, 16'hC000);
    run(2, 0, 100);
    chk("send ticks", 16'(n), 16'd17);
    run(0, 0, 100);
    chk("latched", 16'(n), 16'd17);
    run(0, 0, 40);
    chk("cleared", {15'h0, engine_busy[0]}, 16'h1);
    pulse(2, 1'b1, 6'h00);
    wait_end(0, 60);
    chk("released", {15'h0, end_irq[0]}, 16'h1);
    run(0, 0, 40);
    h = irqs;
    pulse(0, 1'b0, 6'h00);
    repeat (80) @(negedge clock);
    chk("stall stop", {15'h0, engine_busy[0]} | 16'(irqs - h), 16'h0);
    $display("sync test done");
    test_done();
  end
endmodule : pwm_script_instruction_executor_test
`default_nettype wire
